// file: rtl/gpp_pkg.sv
// Operation
// - port 4 pull-up enable bit 1 connects the internal pull-up to its pin.
// - a pin driving low has its pull-up disconnected; on port 4 only 3 clock edges after its P4_DRIVE_LOW bit goes high.
// - ordinary port 6 data read returns sampled pin levels.
// - read-modify-write data read returns the output latch instead.
// - data write updates the latch; output pins drive the latch value.
// - direction bit 0 makes input, 1 makes output driven from latch.
// - port 6 and 7 pull-up bits: 0 disables, 1 enables the pull-up.
// - port 6 register bits 0 to 7 map to pins 60 to 67.
// - port 7 bits 0 to 7 map to pins 70 to 77, same semantics.
// - port 7 open-drain pin with latch 1 and output enabled floats.
// - ordinary port 7 data read returns sampled pin levels.
// - data write on an input pin only updates the latch.
// - reset clears all direction bits, every pin starts as input.
package gpp_pkg;

	localparam int unsigned ADDR_W = 4;
	localparam int unsigned PORT_W = 8;

	// ****************************************
	// register offsets
	// ****************************************
	localparam logic [3:0] OFS_P6_LATCH = 4'h0;
	localparam logic [3:0] OFS_P6_DIR   = 4'h1;
	localparam logic [3:0] OFS_P6_PULL  = 4'h2;
	localparam logic [3:0] OFS_P7_LATCH = 4'h3;
	localparam logic [3:0] OFS_P7_DIR   = 4'h4;
	localparam logic [3:0] OFS_P7_PULL  = 4'h5;
	localparam logic [3:0] OFS_P4_PULL  = 4'h6;

	// ****************************************
	// reset values
	// ****************************************
	localparam logic [7:0] RST_LATCH = 8'h00;
	localparam logic [7:0] RST_DIR   = 8'h00;
	localparam logic [7:0] RST_PULL  = 8'h00;
	localparam logic [7:0] RST_OD7   = 8'h00;

	typedef struct packed {
		logic [7:0] latch;
		logic [7:0] dir;
		logic [7:0] pull;
	} gpp_port_t;

	typedef struct packed {
		logic [7:0] dout;
		logic [7:0] oe_n;
		logic [7:0] pull;
	} gpp_pins_t;

endpackage

// file: rtl/gpp_pad.sv
`timescale 1ns/1ps
`default_nettype none
module gpp_pad #(
	parameter int unsigned WIDTH = 8
) (
	input  wire logic             CLK,
	input  wire logic             SYS_RST,
	input  wire logic [WIDTH-1:0] latch,
	input  wire logic [WIDTH-1:0] dir,
	input  wire logic [WIDTH-1:0] pull,
	input  wire logic [WIDTH-1:0] od,
	input  wire logic [WIDTH-1:0] pin_in,
	output logic      [WIDTH-1:0] pin_sync,
	output logic      [WIDTH-1:0] dout_r,
	output logic      [WIDTH-1:0] oe_n_r,
	output logic      [WIDTH-1:0] pull_r
);

	logic [WIDTH-1:0] meta_r;
	logic [WIDTH-1:0] dout_nxt;
	logic [WIDTH-1:0] oe_n_nxt;
	logic [WIDTH-1:0] pull_nxt;
	logic [WIDTH-1:0] drive;

	// ****************************************
	// pad drive
	// ****************************************
	always_comb begin
		drive    = dir & ~(od & latch);
		dout_nxt = latch;
		oe_n_nxt = ~drive;
		pull_nxt = pull & ~(drive & ~latch);
	end

	always_ff @(posedge CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			meta_r   <= '0;
			pin_sync <= '0;
			dout_r   <= '0;
			oe_n_r   <= '1;
			pull_r   <= '0;
		end else begin
			meta_r   <= pin_in;
			pin_sync <= meta_r;
			dout_r   <= dout_nxt;
			oe_n_r   <= oe_n_nxt;
			pull_r   <= pull_nxt;
		end
	end

endmodule
`default_nettype wire

// file: rtl/gpp_top.sv
`timescale 1ns/1ps
`default_nettype none
module gpp_top #(
	parameter logic [7:0] P7_OPEN_DRAIN = gpp_pkg::RST_OD7
) (
	input  wire logic                       CLK,
	input  wire logic                       SYS_RST,
	input  wire logic [gpp_pkg::ADDR_W-1:0] ADDR,
	input  wire logic [7:0]                 WDATA,
	input  wire logic                       WR,
	input  wire logic                       RD,
	input  wire logic                       RD_RMW,
	output logic      [7:0]                 RDATA,
	input  wire logic [7:0]                 P6_IN,
	output logic      [7:0]                 P6_OUT,
	output logic      [7:0]                 P6_OE_N,
	output logic      [7:0]                 P6_PULLUP,
	input  wire logic [7:0]                 P7_IN,
	output logic      [7:0]                 P7_OUT,
	output logic      [7:0]                 P7_OE_N,
	output logic      [7:0]                 P7_PULLUP,
	input  wire logic [7:0]                 P4_DRIVE_LOW,
	output logic      [7:0]                 P4_PULLUP
);

	gpp_pkg::gpp_port_t p6_r;
	gpp_pkg::gpp_port_t p6_nxt;
	gpp_pkg::gpp_port_t p7_r;
	gpp_pkg::gpp_port_t p7_nxt;
	logic [7:0]         p4_pull_r;
	logic [7:0]         p4_pull_nxt;
	logic [7:0]         p4_low_meta_r;
	logic [7:0]         p4_low_r;
	logic [7:0]         p4_pullup_nxt;
	logic [7:0]         rdata_nxt;
	logic [7:0]         p6_sync;
	logic [7:0]         p7_sync;

	// bit i of every register maps to pin i of its port
	function automatic logic [7:0] data_read(input logic rmw, input logic [7:0] latch,
		input logic [7:0] pins);
		data_read = rmw ? latch : pins;
	endfunction

	// ****************************************
	// register writes
	// ****************************************
	always_comb begin
		p6_nxt      = p6_r;
		p7_nxt      = p7_r;
		p4_pull_nxt = p4_pull_r;
		if (WR) begin
			unique case (ADDR)
				gpp_pkg::OFS_P6_LATCH: p6_nxt.latch = WDATA;
				gpp_pkg::OFS_P6_DIR:   p6_nxt.dir   = WDATA;
				gpp_pkg::OFS_P6_PULL:  p6_nxt.pull  = WDATA;
				gpp_pkg::OFS_P7_LATCH: p7_nxt.latch = WDATA;
				gpp_pkg::OFS_P7_DIR:   p7_nxt.dir   = WDATA;
				gpp_pkg::OFS_P7_PULL:  p7_nxt.pull  = WDATA;
				gpp_pkg::OFS_P4_PULL:  p4_pull_nxt  = WDATA;
				default: ;
			endcase
		end
	end

	// ****************************************
	// read mux
	// ****************************************
	always_comb begin
		rdata_nxt = 8'h00;
		if (RD) begin
			unique case (ADDR)
				gpp_pkg::OFS_P6_LATCH: rdata_nxt = data_read(RD_RMW, p6_r.latch, p6_sync);
				gpp_pkg::OFS_P6_DIR:   rdata_nxt = p6_r.dir;
				gpp_pkg::OFS_P6_PULL:  rdata_nxt = p6_r.pull;
				gpp_pkg::OFS_P7_LATCH: rdata_nxt = data_read(RD_RMW, p7_r.latch, p7_sync);
				gpp_pkg::OFS_P7_DIR:   rdata_nxt = p7_r.dir;
				gpp_pkg::OFS_P7_PULL:  rdata_nxt = p7_r.pull;
				gpp_pkg::OFS_P4_PULL:  rdata_nxt = p4_pull_r;
				default:               rdata_nxt = 8'h00;
			endcase
		end
	end

	// port 4 drives its pins elsewhere; only its pull-up gating lives here
	always_comb begin
		p4_pullup_nxt = p4_pull_r & ~p4_low_r;
	end

	always_ff @(posedge CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			p6_r          <= '{latch: gpp_pkg::RST_LATCH, dir: gpp_pkg::RST_DIR,
				pull: gpp_pkg::RST_PULL};
			p7_r          <= '{latch: gpp_pkg::RST_LATCH, dir: gpp_pkg::RST_DIR,
				pull: gpp_pkg::RST_PULL};
			p4_pull_r     <= gpp_pkg::RST_PULL;
			p4_low_meta_r <= 8'h00;
			p4_low_r      <= 8'h00;
			RDATA         <= 8'h00;
			P4_PULLUP     <= 8'h00;
		end else begin
			p6_r          <= p6_nxt;
			p7_r          <= p7_nxt;
			p4_pull_r     <= p4_pull_nxt;
			p4_low_meta_r <= P4_DRIVE_LOW;
			p4_low_r      <= p4_low_meta_r;
			RDATA         <= rdata_nxt;
			P4_PULLUP     <= p4_pullup_nxt;
		end
	end

	// ****************************************
	// pads
	// ****************************************
	gpp_pad #(.WIDTH(8)) u_p6 (
		.CLK      (CLK),
		.SYS_RST  (SYS_RST),
		.latch    (p6_r.latch),
		.dir      (p6_r.dir),
		.pull     (p6_r.pull),
		.od       (8'h00),
		.pin_in   (P6_IN),
		.pin_sync (p6_sync),
		.dout_r   (P6_OUT),
		.oe_n_r   (P6_OE_N),
		.pull_r   (P6_PULLUP)
	);

	gpp_pad #(.WIDTH(8)) u_p7 (
		.CLK      (CLK),
		.SYS_RST  (SYS_RST),
		.latch    (p7_r.latch),
		.dir      (p7_r.dir),
		.pull     (p7_r.pull),
		.od       (P7_OPEN_DRAIN),
		.pin_in   (P7_IN),
		.pin_sync (p7_sync),
		.dout_r   (P7_OUT),
		.oe_n_r   (P7_OE_N),
		.pull_r   (P7_PULLUP)
	);

endmodule
`default_nettype wire

// file: testbench/gpp_top_sva.sv
`timescale 1ns/1ps
`default_nettype none
module gpp_top_sva #(
	parameter logic [7:0] P7_OPEN_DRAIN = 8'h00
) (
	input wire logic                       CLK,
	input wire logic                       SYS_RST,
	input wire logic [gpp_pkg::ADDR_W-1:0] ADDR,
	input wire logic [7:0]                 WDATA,
	input wire logic                       WR,
	input wire logic                       RD,
	input wire logic                       RD_RMW,
	input wire logic [7:0]                 RDATA,
	input wire logic [7:0]                 P6_IN,
	input wire logic [7:0]                 P6_OUT,
	input wire logic [7:0]                 P6_OE_N,
	input wire logic [7:0]                 P6_PULLUP,
	input wire logic [7:0]                 P7_OUT,
	input wire logic [7:0]                 P7_OE_N,
	input wire logic [7:0]                 P7_PULLUP,
	input wire logic [7:0]                 P4_DRIVE_LOW,
	input wire logic [7:0]                 P4_PULLUP
);
	default clocking cb @(posedge CLK); endclocking
	default disable iff (SYS_RST);
	chk_rst_pads: assert property ($fell(SYS_RST) |->
		P6_OE_N == 8'hff && P7_OE_N == 8'hff && P4_PULLUP == 8'h00) else $error("pads not idle");
	chk_p6_out: assert property (WR && ADDR == 4'h0 |->
		##2 P6_OUT == $past(WDATA, 2)) else $error("p6 out wrong");
	chk_p6_dir: assert property (WR && ADDR == 4'h1 |->
		##2 P6_OE_N == ~$past(WDATA, 2)) else $error("p6 enable wrong");
	chk_rmw_read: assert property (RD && RD_RMW && ADDR == 4'h0 |=>
		RDATA == P6_OUT) else $error("rmw read wrong");
	chk_pin_read: assert property ($stable(P6_IN)[*3] ##0 RD && !RD_RMW && ADDR == 4'h0 |=>
		RDATA == $past(P6_IN)) else $error("pin read wrong");
	chk_od_float: assert property ((P7_OPEN_DRAIN & P7_OUT & ~P7_OE_N) == 8'h00)
		else $error("open drain driven high");
	chk_pull_low: assert property (((P6_PULLUP & ~P6_OE_N & ~P6_OUT)
		| (P7_PULLUP & ~P7_OE_N & ~P7_OUT)) == 8'h00) else $error("pull on low pin");
	chk_p4_cut: assert property ($stable(P4_DRIVE_LOW)[*4] |->
		(P4_PULLUP & P4_DRIVE_LOW) == 8'h00) else $error("p4 pull on low pin");
endmodule
bind gpp_top gpp_top_sva #(.P7_OPEN_DRAIN(P7_OPEN_DRAIN)) gpp_top_sva_i (.CLK, .SYS_RST, .ADDR,
	.WDATA, .WR, .RD, .RD_RMW, .RDATA, .P6_IN, .P6_OUT, .P6_OE_N, .P6_PULLUP, .P7_OUT,
	.P7_OE_N, .P7_PULLUP, .P4_DRIVE_LOW, .P4_PULLUP);
`default_nettype wire

// file: testbench/tb_gpp_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_gpp_top;
	localparam logic [7:0] OD = 8'hf0;
	logic       CLK = 1'b0;
	logic       SYS_RST = 1'b1;
	logic [3:0] ADDR = 4'h0;
	logic [7:0] WDATA = 8'h00;
	logic       WR = 1'b0;
	logic       RD = 1'b0;
	logic       RD_RMW = 1'b0;
	logic [7:0] P6_IN = 8'h00;
	logic [7:0] P7_IN = 8'h00;
	logic [7:0] P4_DRIVE_LOW = 8'h00;
	wire  [7:0] RDATA, P6_OUT, P6_OE_N, P6_PULLUP, P7_OUT, P7_OE_N, P7_PULLUP, P4_PULLUP;
	logic [7:0] m [0:15];
	logic [3:0] a;
	logic       rmw;
	integer     n_errors = 0, check_count = 0, cyc = 0, seed = 32'h18bc, i;
	gpp_top #(.P7_OPEN_DRAIN(OD)) gpp_top_i (.CLK, .SYS_RST, .ADDR, .WDATA, .WR, .RD,
		.RD_RMW, .RDATA, .P6_IN, .P6_OUT, .P6_OE_N, .P6_PULLUP, .P7_IN, .P7_OUT, .P7_OE_N,
		.P7_PULLUP, .P4_DRIVE_LOW, .P4_PULLUP);
	task cmp(input string s, input logic [7:0] e, input logic [7:0] g);
		check_count++;
		if (g !== e) begin
			n_errors++;
			$display("[ERR] %s exp %h got %h", s, e, g);
		end
	endtask
	task wr(input logic [3:0] ad, input logic [7:0] d);
		ADDR <= ad;
		WDATA <= d;
		WR <= 1'b1;
		@(posedge CLK);
		WR <= 1'b0;
		m[ad] = d;
	endtask
	task rd(input logic [3:0] ad, input logic r, input logic [7:0] e);
		ADDR <= ad;
		RD <= 1'b1;
		RD_RMW <= r;
		@(posedge CLK);
		RD <= 1'b0;
		RD_RMW <= 1'b0;
		@(negedge CLK);
		cmp("rdata", e, RDATA);
		@(posedge CLK);
	endtask
	// unmapped places read as zero
	function automatic logic [7:0] ex(input logic [3:0] ad, input logic r);
		if (ad > 4'h6) return 8'h00;
		if (ad == 4'h0 && !r) return P6_IN;
		if (ad == 4'h3 && !r) return P7_IN;
		return m[ad];
	endfunction
	task pads;
		cmp("p6_out", m[0], P6_OUT);
		cmp("p6_oe_n", ~m[1], P6_OE_N);
		cmp("p6_pull", m[2] & ~(m[1] & ~m[0]), P6_PULLUP);
		cmp("p7_out", m[3], P7_OUT);
		cmp("p7_oe_n", ~m[4] | (OD & m[3]), P7_OE_N);
		cmp("p7_pull", m[5] & ~(m[4] & ~m[3]), P7_PULLUP);
		cmp("p4_pull", m[6] & ~P4_DRIVE_LOW, P4_PULLUP);
	endtask
	task test_done;
		if (n_errors == 0 && check_count > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	initial begin
		forever #20 CLK = ~CLK;
	end
	always @(posedge CLK) begin
		cyc <= cyc + 1;
		if (cyc == 4000) begin
			n_errors++;
			test_done;
		end
	end
	initial begin
		for (i = 0; i < 16; i++) m[i] = 8'h00;
		repeat (6) @(posedge CLK);
		SYS_RST <= 1'b0;
		// pads looked at mid-cycle, never in the edge's own time step
		@(negedge CLK);
		pads;
		@(posedge CLK);
		for (i = 0; i < 7; i++) rd(i[3:0], 1'b1, 8'h00);
		// pins held 4 cycles so the synchroniser has settled before the read
		repeat (300) begin
			P6_IN <= 8'($random(seed));
			P7_IN <= 8'($random(seed));
			P4_DRIVE_LOW <= 8'($random(seed));
			repeat (4) @(posedge CLK);
			a = 4'($unsigned($random(seed)) % 9);
			wr(a, 8'($random(seed)));
			a = 4'($unsigned($random(seed)) % 9);
			rmw = 1'($random(seed));
			rd(a, rmw, ex(a, rmw));
			@(negedge CLK);
			pads;
			@(posedge CLK);
		end
		// port 4 pull-up dropped before the pin goes to analog use
		wr(4'h6, 8'h00);
		rd(4'h6, 1'b0, 8'h00);
		@(negedge CLK);
		pads;
		@(posedge CLK);
		// reset in mid-run must clear every register the loop has set
		SYS_RST <= 1'b1;
		@(posedge CLK);
		SYS_RST <= 1'b0;
		for (i = 0; i < 16; i++) m[i] = 8'h00;
		@(negedge CLK);
		pads;
		@(posedge CLK);
		for (i = 0; i < 7; i++) rd(i[3:0], 1'b1, 8'h00);
		test_done;
	end
endmodule
`default_nettype wire
